// [logic/triple_buck_config_sequencer.sv]
// configuration registers, serial-bus slave and start-up sequencer of a triple buck converter
// assumes bus pins and comparator results are synchronous to clock; analog loops sit outside
//
// Operation
// (R1) three output-voltage registers at sub-addresses 00h..02h, 6-bit code each
// (R2) bit 7 of a voltage register selects external divider feedback
// (R3) low five bits of 09h set switching frequency, 300 kHz plus 100 kHz steps
// (R4) low three bits of 06h..08h set each peak current limit
// (R5) low three bits of 03h..05h set soft-start of converters 1..3
// (R6) soft-start counts switching cycles, 500 per step at 1 MHz
// (R7) a converter starts only with enable high and its select bit set
// (R8) bits 6..4 of the timing register set the start-up delay
// (R9) start-up delay counts switching cycles, 5000 per step at 1 MHz
// (R10) sync input ignored until power-good has been asserted
// (R11) host keeps internal frequency below the sync frequency
// (R12) locking to sync scales all cycle-counted timings with it
// (R13) bits 6..5 of 09h pick in-phase or one converter shifted 180 degrees
// (R14) light-load mode enables zero-current turn-off and pulse skipping together
// (R15) host sets opposite phase and equal voltage codes for paralleled converters
// (R16) power-good drops below 85 percent, rises after 90 percent plus reset timer
// (R17) power-on copies the nonvolatile store into registers, bus held off meanwhile
// (R18) every setting field maps linearly from code zero upward, except that frequency codes above 19 are held at 19
// (R19) unselected converters stay off and are left out of power-good
module triple_buck_config_sequencer
    import buck_seq_pkg::*;
#(
    parameter int         PG_RESET_CYCLES = PG_RESET_SW,
    parameter int         DLY_STEP_CYCLES = DLY_STEP_SW,
    parameter int         SS_STEP_CYCLES  = SS_STEP_SW,
    parameter logic [6:0] BUS_ADDR        = BUS_ADDR_DEFAULT,
    parameter int         CNT_W           = 20
)(
    input  wire logic                        clock,
    input  wire logic                        srst,
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe,
    input  wire logic                        enable_in,
    input  wire logic [NUM_CH-1:0]           channel_select,
    input  wire logic                        sync_in,
    input  wire logic                        light_load_skip_mode,
    input  wire reg_image_t                  nonvolatile_store,
    input  wire output_sense_t [NUM_CH-1:0]  output_sense,
    output chan_ctrl_t [NUM_CH-1:0]          chan_ctrl,
    output logic [NUM_CH-1:0]                switch_pulse,
    output logic [FSW_W-1:0]                 fsw_code,
    output logic                             zero_current_detector_en,
    output logic                             pulse_skip_en,
    output logic                             constant_frequency_conduction,
    output logic                             power_good_out,
    output logic                             power_good_pull_oe,
    output logic                             nv_load_busy
);

    reg_image_t         regs_q;
    logic               loading_q;
    logic [CNT_W-1:0]   load_cnt_q;
    logic               pg_q;
    logic [CNT_W-1:0]   pg_cnt_q;
    logic [NUM_CH-1:0]  ch_ok;
    logic [NUM_CH-1:0]  ch_low;
    logic [NUM_CH-1:0]  pulse_q;
    logic               ll_q;

    ////////////////////////////////////////////////////////////////////////////
    // power-on load from the nonvolatile store

    wire load_last = loading_q & (load_cnt_q == CNT_W'(NV_LOAD_CYC - 1));

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            loading_q  <= 1'b1;
            load_cnt_q <= '0;
        end
        else if (loading_q)
        begin
            loading_q  <= ~load_last; // R17
            load_cnt_q <= load_cnt_q + CNT_W'(1);
        end
    end

    assign nv_load_busy = loading_q;

    ////////////////////////////////////////////////////////////////////////////
    // serial bus slave, open drain data line

    bus_state_t  bst_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic [7:0]  sub_q;
    logic        ack_q;
    logic        rw_q;
    logic        scl_q;
    logic        sda_q;

    wire scl_rise  = scl_in & ~scl_q;
    wire scl_fall  = ~scl_in & scl_q;
    wire bus_start = scl_in & scl_q & sda_q & ~sda_in;
    wire bus_stop  = scl_in & scl_q & ~sda_q & sda_in;
    wire byte_end  = scl_fall & (bit_q == 4'h7);
    wire ack_end   = scl_fall & (bit_q == 4'h8);
    wire sub_hit   = sub_q < 8'(NUM_REGS);
    // the slave stays deaf while the store is being copied
    wire addr_ok   = (sh_q[7:1] == BUS_ADDR) & ~loading_q; // R17
    wire wr_en     = byte_end & (bst_q == BUS_WR) & sub_hit;
    wire [7:0] rd_data = sub_hit ? regs_q[sub_q[3:0]] : 8'h00;
    wire next_rd   = (bst_q == BUS_RD) | ((bst_q == BUS_ADR) & rw_q);

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst | bus_stop)
        begin
            bst_q <= BUS_IDLE;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
        end
        else if (bus_start)
        begin
            bst_q <= BUS_ADR;
            // the scl fall that closes the start wraps this to zero, so it is not counted as a bit
            bit_q <= 4'hF;
            ack_q <= 1'b0;
        end
        else if (bst_q != BUS_IDLE)
        begin
            if (scl_rise & (bit_q < 4'h8) & (bst_q != BUS_RD))
                sh_q <= {sh_q[6:0], sda_in};
            if (scl_rise & (bit_q == 4'h8) & (bst_q == BUS_RD) & sda_in)
                bst_q <= BUS_IDLE;
            if (byte_end)
            begin
                bit_q <= 4'h8;
                ack_q <= (bst_q != BUS_RD) & ((bst_q != BUS_ADR) | addr_ok);
                case (bst_q)
                    BUS_ADR:
                    begin
                        rw_q <= sh_q[0];
                        if (!addr_ok)
                            bst_q <= BUS_IDLE;
                    end
                    BUS_SUB: sub_q <= sh_q;
                    BUS_WR:  sub_q <= sub_q + 8'h01;
                    default: ;
                endcase
            end
            else if (ack_end)
            begin
                bit_q <= 4'h0;
                ack_q <= 1'b0;
                if (next_rd)
                begin
                    bst_q <= BUS_RD;
                    sh_q  <= rd_data;
                    sub_q <= sub_q + 8'h01;
                end
                else if (bst_q == BUS_ADR)
                    bst_q <= BUS_SUB;
                else
                    bst_q <= BUS_WR;
            end
            else if (scl_fall)
            begin
                bit_q <= bit_q + 4'h1;
                if (bst_q == BUS_RD)
                    sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = ack_q | ((bst_q == BUS_RD) & (bit_q < 4'h8) & ~sh_q[7]);

    ////////////////////////////////////////////////////////////////////////////
    // register file

    always_ff @(posedge clock)
    begin
        if (srst)
            regs_q <= '0;
        else if (load_last)
            regs_q <= nonvolatile_store; // R17
        else if (wr_en)
            regs_q[sub_q[3:0]] <= sh_q; // R1 R4 R5
    end

    ////////////////////////////////////////////////////////////////////////////
    // switching oscillator and sync

    logic [ACC_W-1:0] acc_q;
    logic             sync_q;
    logic             sync_lock_q;

    wire [FSW_W-1:0] fcode_raw = regs_q[OFS_FREQ][FSW_W-1:0];
    // codes above the top of the range are held at the top rather than overclocking
    wire [FSW_W-1:0] fcode = (fcode_raw > FSW_CODE_MAX) ? FSW_CODE_MAX : fcode_raw; // R3
    wire [ACC_W-1:0] inc = ACC_W'(fcode) + ACC_W'(FSW_BASE_STEPS); // R18
    wire [ACC_W-1:0] acc_sum = acc_q + inc;
    wire osc_wrap  = acc_sum >= ACC_W'(ACC_FULL);
    wire half_tick = (acc_q < ACC_W'(ACC_HALF)) & (acc_sum >= ACC_W'(ACC_HALF));
    wire sync_rise = sync_in & ~sync_q;
    // once locked every count below advances on the external edge
    wire sw_tick = sync_lock_q ? sync_rise : osc_wrap; // R12
    wire [PHASE_W-1:0] phase_sel = regs_q[OFS_FREQ][PHASE_LSB +: PHASE_W];

    always_ff @(posedge clock)
    begin
        if (srst)
            acc_q <= '0;
        else if (sync_lock_q & sync_rise)
            acc_q <= '0; // R11
        else
            acc_q <= osc_wrap ? acc_sum - ACC_W'(ACC_FULL) : acc_sum;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            sync_q      <= 1'b0;
            sync_lock_q <= 1'b0;
        end
        else
        begin
            sync_q      <= sync_in;
            sync_lock_q <= pg_q & (sync_lock_q | sync_rise); // R10
        end
    end

    assign fsw_code = fcode;

    ////////////////////////////////////////////////////////////////////////////
    // per-channel sequencers

    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        ch_state_t        st_q;
        logic [CNT_W-1:0] cnt_q;

        wire [7:0] tim  = regs_q[OFS_TIMING0 + i];
        wire [7:0] vreg = regs_q[OFS_VOUT0 + i];
        wire       go   = enable_in & channel_select[i]; // R7 R19
        wire [CNT_W-1:0] dly_lim =
            CNT_W'(tim[DLY_LSB +: TCODE_W]) * CNT_W'(DLY_STEP_CYCLES); // R8 R9
        wire [CNT_W-1:0] ss_lim =
            (CNT_W'(tim[TCODE_W-1:0]) + CNT_W'(1)) * CNT_W'(SS_STEP_CYCLES); // R5 R6
        wire shifted = phase_sel == PHASE_W'(i + 1); // R13
        wire run     = (st_q == CH_SOFT) | (st_q == CH_ON);

        always_ff @(posedge clock)
        begin
            if (srst | ~go)
            begin
                st_q  <= CH_OFF; // R19
                cnt_q <= '0;
            end
            else
            begin
                case (st_q)
                    CH_OFF:
                    begin
                        st_q  <= CH_DELAY; // R7
                        cnt_q <= '0;
                    end
                    CH_DELAY:
                        if (cnt_q == dly_lim)
                        begin
                            st_q  <= CH_SOFT; // R8
                            cnt_q <= '0;
                        end
                        else if (sw_tick)
                            cnt_q <= cnt_q + CNT_W'(1);
                    CH_SOFT:
                        if (cnt_q == ss_lim)
                            st_q <= CH_ON; // R6
                        else if (sw_tick)
                            cnt_q <= cnt_q + CNT_W'(1);
                    CH_ON: ;
                    default: st_q <= CH_OFF;
                endcase
            end
        end

        always_ff @(posedge clock)
        begin
            if (srst)
                pulse_q[i] <= 1'b0;
            else
                pulse_q[i] <= run & (shifted ? half_tick : sw_tick); // R13
        end

        assign chan_ctrl[i] = {run, st_q == CH_SOFT, vreg[EXT_FB_BIT], // R2
                               vreg[VCODE_W-1:0], // R1
                               regs_q[OFS_ILIM0 + i][ILIM_W-1:0]}; // R4
        assign ch_ok[i]  = ~go | ((st_q == CH_ON) & output_sense[i].above_90); // R19
        assign ch_low[i] = go & ((st_q != CH_ON) | output_sense[i].below_85); // R16
    end

    assign switch_pulse = pulse_q;

    ////////////////////////////////////////////////////////////////////////////
    // power good with hysteresis between the two comparator levels

    wire pg_drop  = ~enable_in | ~(|channel_select) | (|ch_low);
    wire pg_ready = &ch_ok;

    always_ff @(posedge clock)
    begin
        if (srst | pg_drop | (~pg_q & ~pg_ready))
        begin
            pg_q     <= 1'b0; // R16
            pg_cnt_q <= '0;
        end
        else if (sw_tick & ~pg_q)
        begin
            if (pg_cnt_q == CNT_W'(PG_RESET_CYCLES - 1))
                pg_q <= 1'b1; // R16
            else
                pg_cnt_q <= pg_cnt_q + CNT_W'(1);
        end
    end

    assign power_good_out     = pg_q;
    assign power_good_pull_oe = ~pg_q;

    ////////////////////////////////////////////////////////////////////////////
    // light-load mode

    always_ff @(posedge clock)
    begin
        if (srst)
            ll_q <= 1'b0;
        else
            ll_q <= light_load_skip_mode;
    end

    assign zero_current_detector_en      = ll_q; // R14
    assign pulse_skip_en                 = ll_q; // R14
    assign constant_frequency_conduction = ~ll_q;

endmodule

// [logic/buck_seq_pkg.sv]
// constants, field layouts and carrier types of the three-channel buck sequencer
// assumes one 20 MHz system clock and a single sequencer instance per device
package buck_seq_pkg;

    localparam int NUM_CH   = 3;
    localparam int NUM_REGS = 10;

    // register offsets (byte sub-addresses on the serial bus)
    localparam int OFS_VOUT0  = 'h00;
    localparam int OFS_TIMING0 = 'h03;
    localparam int OFS_ILIM0  = 'h06;
    localparam int OFS_FREQ   = 'h09;

    // field layouts
    localparam int EXT_FB_BIT = 7;
    localparam int VCODE_W    = 6;
    localparam int ILIM_W     = 3;
    localparam int TCODE_W    = 3;
    localparam int DLY_LSB    = 4;
    localparam int FSW_W      = 5;
    localparam int PHASE_LSB  = 5;
    localparam int PHASE_W    = 2;

    // timing figures in their own units
    localparam int CLK_NS       = 50;
    localparam int CLK_KHZ      = 20000;
    localparam int FSW_STEP_KHZ = 100;
    localparam int FSW_BASE_KHZ = 300;
    localparam int FSW_MAX_KHZ  = 2200;
    localparam int REF_FSW_KHZ  = 1000;
    localparam int DLY_STEP_US  = 5000;
    localparam int SS_STEP_US   = 500;
    localparam int PG_RESET_US  = 1000000;
    localparam int NV_LOAD_NS   = 200000;

    // derived counts
    localparam int ACC_W          = 8;
    localparam int ACC_FULL       = CLK_KHZ / FSW_STEP_KHZ;
    localparam int ACC_HALF       = ACC_FULL / 2;
    localparam int FSW_BASE_STEPS = FSW_BASE_KHZ / FSW_STEP_KHZ;
    localparam logic [FSW_W-1:0] FSW_CODE_MAX = FSW_W'((FSW_MAX_KHZ - FSW_BASE_KHZ) / FSW_STEP_KHZ);
    localparam int DLY_STEP_SW    = DLY_STEP_US * REF_FSW_KHZ / 1000;
    localparam int SS_STEP_SW     = SS_STEP_US * REF_FSW_KHZ / 1000;
    localparam int PG_RESET_SW    = PG_RESET_US / 1000 * REF_FSW_KHZ;
    localparam int NV_LOAD_CYC    = (NV_LOAD_NS + CLK_NS - 1) / CLK_NS;

    // serial bus slave address, value arbitrary
    localparam logic [6:0] BUS_ADDR_DEFAULT = 7'h2A;

    typedef logic [NUM_REGS-1:0][7:0] reg_image_t;

    typedef enum logic [1:0] {
        CH_OFF   = 2'b00,
        CH_DELAY = 2'b01,
        CH_SOFT  = 2'b10,
        CH_ON    = 2'b11
    } ch_state_t;

    typedef enum logic [2:0] {
        BUS_IDLE = 3'b000,
        BUS_ADR  = 3'b001,
        BUS_SUB  = 3'b010,
        BUS_WR   = 3'b011,
        BUS_RD   = 3'b100
    } bus_state_t;

    typedef struct packed {
        logic                 run;
        logic                 soft_start;
        logic                 external_feedback_select;
        logic [VCODE_W-1:0]   vout_code;
        logic [ILIM_W-1:0]    ilim_code;
    } chan_ctrl_t;

    typedef struct packed {
        logic above_90;
        logic below_85;
    } output_sense_t;

endpackage

// [sim/buck_seq_sva.sv]
// concurrent checks on the triple buck sequencer ports
// assumes the design's single clock domain and synchronous reset
module buck_seq_sva
    import buck_seq_pkg::*;
(
    input wire logic                       clock,
    input wire logic                       srst,
    input wire logic                       sda_oe,
    input wire logic                       enable_in,
    input wire logic [NUM_CH-1:0]          channel_select,
    input wire output_sense_t [NUM_CH-1:0] output_sense,
    input wire chan_ctrl_t [NUM_CH-1:0]    chan_ctrl,
    input wire logic [NUM_CH-1:0]          switch_pulse,
    input wire logic [FSW_W-1:0]           fsw_code,
    input wire logic                       zero_current_detector_en,
    input wire logic                       pulse_skip_en,
    input wire logic                       constant_frequency_conduction,
    input wire logic                       power_good_out,
    input wire logic                       power_good_pull_oe,
    input wire logic                       nv_load_busy
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [NUM_CH-1:0] run;
    logic [NUM_CH-1:0] low_sel;
    int                busy_q;

    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
        assign run[i] = chan_ctrl[i].run;
        assign low_sel[i] = output_sense[i].below_85 & channel_select[i];
    end

    // load is too long for a delay range, so it is bounded by a counter
    always_ff @(posedge clock)
        busy_q <= (srst || !nv_load_busy) ? 0 : busy_q + 1;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);

    chk_pg_pull: assert property (power_good_pull_oe == !power_good_out)
        else $error("pull level wrong");
    chk_pg_drop: assert property ((power_good_out && (|low_sel)) |=> !power_good_out)
        else $error("power good held");
    chk_pg_cause: assert property ($rose(power_good_out) |-> $past(enable_in) && ($past(run) != '0))
        else $error("power good without run");
    chk_unsel_off: assert property ((run & ~$past(channel_select)) == '0)
        else $error("unselected running");
    chk_enable_off: assert property (!$past(enable_in) |-> run == '0)
        else $error("running while disabled");
    chk_soft_first: assert property ($rose(run[0]) |-> chan_ctrl[0].soft_start)
        else $error("start skipped soft start");
    // sync locking may place a tick close to an oscillator tick, so locked spans are skipped
    chk_pulse_gap: assert property ((switch_pulse[0] && !power_good_out && !$past(power_good_out))
        |=> !switch_pulse[0] [*8])
        else $error("switching too fast");
    chk_fsw_clamp: assert property (fsw_code <= FSW_CODE_MAX)
        else $error("frequency code out of range");
    chk_busy_quiet: assert property (nv_load_busy |-> !sda_oe)
        else $error("bus answered during load");
    chk_load_len: assert property (nv_load_busy |-> busy_q < NV_LOAD_CYC + 2)
        else $error("load too long");
    chk_light_pair: assert property (pulse_skip_en == zero_current_detector_en
        && constant_frequency_conduction == !pulse_skip_en)
        else $error("light load pair split");
endmodule

////////////////////////////////////////
bind triple_buck_config_sequencer buck_seq_sva u_sva (
    .clock(clock), .srst(srst), .sda_oe(sda_oe), .enable_in(enable_in), .channel_select(channel_select),
    .output_sense(output_sense), .chan_ctrl(chan_ctrl), .switch_pulse(switch_pulse), .fsw_code(fsw_code),
    .zero_current_detector_en(zero_current_detector_en), .pulse_skip_en(pulse_skip_en),
    .constant_frequency_conduction(constant_frequency_conduction), .power_good_out(power_good_out),
    .power_good_pull_oe(power_good_pull_oe), .nv_load_busy(nv_load_busy)
);

// [sim/bus_host_model.sv]
// serial-bus host and external sync source facing the sequencer
// assumes the bench resolves the open-drain data wire with a pull-up
module bus_host_model
    import buck_seq_pkg::*;
#(
    parameter int HALF = 4
)(
    input  wire logic clock,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv,
    output logic      sync_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic sync_run = 1'b0;
    int   sync_cnt = 0;

    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
        sync_out = 1'b0;
    end

    // 2 MHz, above any oscillator code the bench programs while locked
    always @(posedge clock)
    begin
        sync_cnt <= (sync_cnt == 4) ? 0 : sync_cnt + 1;
        if (sync_cnt == 4)
            sync_out <= sync_run & !sync_out;
    end

    task automatic pins(input logic c, input logic d);
        scl <= c;
        sda_drv <= d;
        repeat (HALF) @(posedge clock);
    endtask

    // data only moves while the clock line is low
    task automatic bit_io(input logic b, output logic r);
        pins(1'b0, b);
        pins(1'b1, b);
        r = sda_line;
        pins(1'b0, b);
    endtask

    task automatic byte_io(input logic [7:0] v, output logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(v[i], r);
            d[i] = r;
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask

    task automatic xfer(input logic [7:0] sub, input logic rd, input logic [7:0] wd,
                        output logic [7:0] q, output logic ok);
        logic [2:0] a;
        logic [7:0] d;
        pins(1'b0, 1'b1);
        pins(1'b1, 1'b1);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
        byte_io({BUS_ADDR_DEFAULT, 1'b0}, d, a[0]);
        byte_io(sub, d, a[1]);
        if (rd)
        begin
            pins(1'b0, 1'b1);
            pins(1'b1, 1'b1);
            pins(1'b1, 1'b0);
            pins(1'b0, 1'b0);
            byte_io({BUS_ADDR_DEFAULT, 1'b1}, d, a[2]);
            byte_io(8'hFF, q, d[0]);
        end
        else
            byte_io(wd, d, a[2]);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b0);
        pins(1'b1, 1'b1);
        ok = &a;
    endtask
endmodule

// [sim/test_triple_buck_config_sequencer.sv]
// self-checking bench for the triple buck sequencer with short timing counts
// assumes the host model owns the bus pins and the sync input
module test_triple_buck_config_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    import buck_seq_pkg::*;

    localparam reg_image_t NV = {8'h07, 8'h03, 8'h02, 8'h01, 8'h21, 8'h12, 8'h21, 8'h05, 8'h04, 8'h83};

    logic                       clock = 1'b0;
    logic                       srst = 1'b1;
    logic                       enable_in = 1'b0;
    logic                       light_load_skip_mode = 1'b0;
    logic [NUM_CH-1:0]          channel_select = '0;
    output_sense_t [NUM_CH-1:0] output_sense = '0;
    chan_ctrl_t [NUM_CH-1:0]    chan_ctrl;
    logic [NUM_CH-1:0]          switch_pulse;
    logic [FSW_W-1:0]           fsw_code;
    logic                       scl, sda_drv, sync_in, sda_out, sda_oe, zcd_en, skip_en, cfc, pg, pg_oe, busy, ok;
    logic [7:0]                 q;
    int                         num_errors = 0;
    int                         n_checks = 0;
    int                         n;
    wire logic                  sda_line = sda_drv & ~(sda_oe & ~sda_out);

    always #25 clock = ~clock;

    triple_buck_config_sequencer #(.PG_RESET_CYCLES(20), .DLY_STEP_CYCLES(3), .SS_STEP_CYCLES(2)) dut_u (
        .clock(clock), .srst(srst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .enable_in(enable_in), .channel_select(channel_select), .sync_in(sync_in),
        .light_load_skip_mode(light_load_skip_mode), .nonvolatile_store(NV), .output_sense(output_sense),
        .chan_ctrl(chan_ctrl), .switch_pulse(switch_pulse), .fsw_code(fsw_code),
        .zero_current_detector_en(zcd_en), .pulse_skip_en(skip_en), .constant_frequency_conduction(cfc),
        .power_good_out(pg), .power_good_pull_oe(pg_oe), .nv_load_busy(busy)
    );
    bus_host_model host_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_drv(sda_drv), .sync_out(sync_in));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic win(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi)
        begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic step();
        @(posedge clock);
        #1;
        n++;
    endtask

    // clocks from a pulse of channel a to the next pulse of channel b, left in n
    task automatic gap(input int a, input int b);
        n = 0;
        while (switch_pulse[a] !== 1'b1 && n < 300) step();
        n = 0;
        do step(); while (switch_pulse[b] !== 1'b1 && n < 300);
    endtask

    task automatic t_load();
        chk({busy, pg, pg_oe}, 3'b101);
        host_u.xfer(8'h00, 1'b0, 8'h11, q, ok);
        chk(ok, 1'b0);
        n = 0;
        while (busy !== 1'b0 && n < 5000) step();
        chk(busy, 1'b0);
        for (int i = 0; i < NUM_CH; i++)
        begin
            chk({chan_ctrl[i].external_feedback_select, chan_ctrl[i].vout_code}, {NV[i][7], NV[i][5:0]});
            chk(chan_ctrl[i].ilim_code, NV[6 + i][2:0]);
        end
        chk(fsw_code, NV[9][4:0]);
        @(posedge clock);
        light_load_skip_mode <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk({zcd_en, skip_en, cfc}, 3'b110);
        $display("TB: load test done");
    endtask

    task automatic t_bus();
        host_u.xfer(8'h00, 1'b0, 8'hA6, q, ok);
        chk({ok, chan_ctrl[0].external_feedback_select, chan_ctrl[0].vout_code}, 8'hE6);
        host_u.xfer(8'h00, 1'b1, 8'h00, q, ok);
        chk(q, 8'hA6);
        host_u.xfer(8'h07, 1'b0, 8'h07, q, ok);
        chk(chan_ctrl[1].ilim_code, 3'h7);
        host_u.xfer(8'h0A, 1'b0, 8'h55, q, ok);
        host_u.xfer(8'h0A, 1'b1, 8'h00, q, ok);
        chk(q, 8'h00);
        host_u.xfer(8'h09, 1'b0, 8'h1F, q, ok);
        chk(fsw_code, 5'h13);
        host_u.xfer(8'h09, 1'b0, 8'h07, q, ok);
        $display("TB: bus test done");
    endtask

    task automatic t_seq();
        host_u.sync_run = 1'b1;
        @(posedge clock);
        channel_select <= 3'b001;
        enable_in <= 1'b1;
        n = 0;
        while (chan_ctrl[0].run !== 1'b1 && n < 500) step();
        win(n, 95, 130);
        chk({chan_ctrl[0].soft_start, chan_ctrl[2].run, chan_ctrl[1].run}, 3'b100);
        n = 0;
        while (chan_ctrl[0].soft_start !== 1'b0 && n < 500) step();
        win(n, 55, 90);
        gap(0, 0);
        chk(n, 20);
        @(posedge clock);
        output_sense[0].above_90 <= 1'b1;
        n = 0;
        while (pg !== 1'b1 && n < 900) step();
        win(n, 380, 430);
        gap(0, 0);
        gap(0, 0);
        chk(n, 10);
        @(posedge clock);
        output_sense[0].below_85 <= 1'b1;
        repeat (2) step();
        chk(pg, 1'b0);
        host_u.sync_run = 1'b0;
        @(posedge clock);
        output_sense <= '0;
        enable_in <= 1'b0;
        repeat (2) step();
        chk(chan_ctrl[0].run, 1'b0);
        $display("TB: sequence test done");
    endtask

    task automatic t_phase();
        host_u.xfer(8'h01, 1'b0, 8'h05, q, ok);
        host_u.xfer(8'h02, 1'b0, 8'h05, q, ok);
        host_u.xfer(8'h09, 1'b0, 8'h47, q, ok);
        @(posedge clock);
        channel_select <= 3'b110;
        enable_in <= 1'b1;
        n = 0;
        while (chan_ctrl[1].run !== 1'b1 && n < 500) step();
        chk({chan_ctrl[1].run, chan_ctrl[2].run, chan_ctrl[0].run}, 3'b100);
        while (chan_ctrl[2].run !== 1'b1 && n < 500) step();
        gap(2, 1);
        chk(n, 10);
        host_u.xfer(8'h09, 1'b0, 8'h07, q, ok);
        gap(2, 1);
        chk(n, 20);
        host_u.xfer(8'h09, 1'b0, 8'h02, q, ok);
        gap(1, 1);
        chk(n, 40);
        @(posedge clock);
        enable_in <= 1'b0;
        $display("TB: phase test done");
    endtask

    task automatic report_and_stop();
        $display("TB: checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        #1;
        t_load();
        t_bus();
        t_seq();
        t_phase();
        report_and_stop();
    end

    // the tests need about 9500 cycles
    initial
    begin
        repeat (40000) @(posedge clock);
        num_errors++;
        report_and_stop();
    end
endmodule
